//--- rtl/difl_core.v
// drive input function logic: terminal routing, run, coast, external trip, registers
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`include "difl_regs.vh"
`default_nettype none
module difl_core #(
  parameter TICK_CYC = `DIFL_TICK_CYC
) (
  input  wire                     mclk,
  input  wire                     rst,
  input  wire [`DIFL_NTERM-1:0]   term_pin,
  input  wire [`DIFL_ADDR_W-1:0]  avs_address,
  input  wire                     avs_read,
  input  wire                     avs_write,
  input  wire [31:0]              avs_writedata,
  output reg  [31:0]              avs_readdata,
  output reg                      avs_waitrequest,
  output reg                      drive_on,
  output reg                      drive_reverse,
  output reg                      motor_set2,
  output reg                      start_from_speed,
  output reg                      alarm,
  output reg  [7:0]               err_code,
  output reg                      irq
);
  // drive states; trip is left only through a reset operation
  localparam [2:0] ST_STOP  = 3'd0;
  localparam [2:0] ST_RUN   = 3'd1;
  localparam [2:0] ST_COAST = 3'd2;
  localparam [2:0] ST_WAIT  = 3'd3;
  localparam [2:0] ST_TRIP  = 3'd4;
  localparam [15:0] TICK_N  = TICK_CYC[15:0];

  reg  [1:0]              ctrl_r;
  reg  [15:0]             delay_r;
  reg  [31:0]             func_lo_r;
  reg  [23:0]             func_hi_r;
  reg  [`DIFL_NTERM-1:0]  pol_r;
  reg  [`DIFL_IRQ_W-1:0]  istat_r;
  reg  [`DIFL_IRQ_W-1:0]  imask_r;
  reg  [7:0]              hist_r;
  reg                     kreset_r;
  reg  [2:0]              state_r;
  reg  [2:0]              state_nxt;
  reg  [15:0]             tick_r;
  reg  [15:0]             wait_r;
  reg                     trip_prev_r;
  reg                     rst_in_prev_r;
  reg                     guard_blk_r;
  reg                     set_chg;
  wire [6*`DIFL_NTERM-1:0] hits;
  reg  [5:0]              fn;
  integer                 i;
  // one flat code vector, so each terminal indexes its own byte
  wire [8*`DIFL_NTERM-1:0] func_all = {func_hi_r, func_lo_r};

  genvar g;
  generate
    for (g = 0; g < `DIFL_NTERM; g = g + 1) begin : g_term
      difl_term u_term (
        .mclk    (mclk),
        .rst     (rst),
        .pin     (term_pin[g]),
        .pol_low (pol_r[g]),
        .func    (func_all[8*g+:8]),
        .hit     (hits[6*g+:6])
      );
    end
  endgenerate

  // terminals sharing a code are ored, so any one of them acts
  always @* begin
    fn = 6'h00;
    for (i = 0; i < `DIFL_NTERM; i = i + 1) begin
      fn = fn | hits[6*i+:6];
    end
  end

  wire fwd_in   = fn[0];
  wire rev_in   = fn[1];
  wire set_in   = fn[2];
  wire coast_in = fn[3];
  wire trip_in  = fn[4];
  wire rstin    = fn[5];
  wire run_cmd  = fwd_in ^ rev_in;
  // edge, not level: a trip input still high after a reset cannot retrip
  wire trip_evt = trip_in && !trip_prev_r;
  // terminal reset acts on release of the input, keypad pulse at once
  wire reset_op = (rst_in_prev_r && !rstin) || kreset_r;
  // free-running ms divider, so the first wait tick may come early
  wire tick     = (tick_r == TICK_N - 16'h0001);
  wire run_ok   = run_cmd && !guard_blk_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_STOP: begin
        if (run_ok && !coast_in) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (coast_in) begin
          state_nxt = ST_COAST;
        end else if (!run_cmd) begin
          state_nxt = ST_STOP;
        end
      end
      ST_COAST: begin
        if (!coast_in) begin
          if (!run_cmd) begin
            state_nxt = ST_STOP;
          end else if (delay_r == 16'h0000) begin
            state_nxt = ST_RUN;
          end else begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (coast_in) begin
          state_nxt = ST_COAST;
        end else if (!run_cmd) begin
          state_nxt = ST_STOP;
        end else if (wait_r == 16'h0000) begin
          state_nxt = ST_RUN;
        end
      end
      ST_TRIP: begin
        if (reset_op) begin
          state_nxt = ST_STOP;
        end
      end
      default: begin
        state_nxt = ST_STOP;
      end
    endcase
    // a trip outranks every other state, coast included
    if (trip_evt && state_r != ST_TRIP) begin
      state_nxt = ST_TRIP;
    end
  end

  // set level only latched in stop, a running motor keeps its set
  always @* begin
    set_chg = (state_r == ST_STOP) && (set_in != motor_set2);
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_r          <= ST_STOP;
      tick_r           <= 16'h0000;
      wait_r           <= 16'h0000;
      trip_prev_r      <= 1'b0;
      rst_in_prev_r    <= 1'b0;
      guard_blk_r      <= 1'b0;
      drive_on         <= 1'b0;
      drive_reverse    <= 1'b0;
      motor_set2       <= 1'b0;
      start_from_speed <= 1'b0;
      alarm            <= 1'b0;
      err_code         <= `DIFL_ERR_NONE;
      hist_r           <= 8'h00;
    end else begin
      state_r       <= state_nxt;
      trip_prev_r   <= trip_in;
      rst_in_prev_r <= rstin;
      tick_r        <= tick ? 16'h0000 : tick_r + 16'h0001;
      // wait counts whole ms ticks; zero delay never enters the wait state
      if (state_nxt == ST_WAIT && state_r != ST_WAIT) begin
        wait_r <= delay_r;
      end else if (state_r == ST_WAIT && tick && wait_r != 16'h0000) begin
        wait_r <= wait_r - 16'h0001;
      end
      if (set_chg) begin
        motor_set2 <= set_in;
      end
      // output goes off in the same edge the coast or trip is seen
      drive_on <= (state_nxt == ST_RUN);
      if (state_nxt == ST_RUN && state_r != ST_RUN) begin
        drive_reverse    <= rev_in;
        // a fresh start always ramps from zero; only a coast resume may match speed
        start_from_speed <= (state_r == ST_COAST || state_r == ST_WAIT)
                            && ctrl_r[`DIFL_CTRL_MODE];
      end
      if (trip_evt && state_r != ST_TRIP) begin
        alarm    <= 1'b1;
        err_code <= `DIFL_ERR_EXT;
        if (hist_r != 8'hFF) begin
          hist_r <= hist_r + 8'h01;
        end
      end else if (state_r == ST_TRIP && reset_op) begin
        alarm       <= 1'b0;
        err_code    <= `DIFL_ERR_NONE;
        hist_r      <= 8'h00;
        guard_blk_r <= ctrl_r[`DIFL_CTRL_GUARD];
      end else if (!run_cmd) begin
        // block lifts only once the run command has dropped
        guard_blk_r <= 1'b0;
      end
    end
  end

  // bus slave: one wait cycle, then waitrequest low for exactly one edge
  wire        req   = avs_read || avs_write;
  wire        wr_go = avs_write && !avs_waitrequest;
  reg  [31:0] rd_mux;
  reg  [`DIFL_IRQ_W-1:0] ev;

  always @* begin
    if (avs_address == `DIFL_OFS_CTRL) begin
      rd_mux = {30'h0000_0000, ctrl_r};
    end else if (avs_address == `DIFL_OFS_DELAY) begin
      rd_mux = {16'h0000, delay_r};
    end else if (avs_address == `DIFL_OFS_FUNC_LO) begin
      rd_mux = func_lo_r;
    end else if (avs_address == `DIFL_OFS_FUNC_HI) begin
      rd_mux = {8'h00, func_hi_r};
    end else if (avs_address == `DIFL_OFS_POL) begin
      rd_mux = {25'h000_0000, pol_r};
    end else if (avs_address == `DIFL_OFS_STATUS) begin
      rd_mux = {16'h0000, err_code, guard_blk_r, motor_set2, alarm, drive_on,
                drive_reverse, state_r};
    end else if (avs_address == `DIFL_OFS_IRQ_STAT) begin
      rd_mux = {28'h000_0000, istat_r};
    end else if (avs_address == `DIFL_OFS_IRQ_MASK) begin
      rd_mux = {28'h000_0000, imask_r};
    end else if (avs_address == `DIFL_OFS_HIST) begin
      rd_mux = {24'h00_0000, hist_r};
    end else begin
      rd_mux = 32'h0000_0000;
    end
    ev = {`DIFL_IRQ_W{1'b0}};
    ev[`DIFL_IRQ_TRIP]   = trip_evt && state_r != ST_TRIP;
    ev[`DIFL_IRQ_COAST]  = state_nxt == ST_COAST && state_r != ST_COAST;
    ev[`DIFL_IRQ_RESUME] = state_nxt == ST_RUN && (state_r == ST_COAST || state_r == ST_WAIT);
    ev[`DIFL_IRQ_SETCHG] = set_chg;
  end

  always @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl_r          <= `DIFL_CTRL_RST;
      delay_r         <= `DIFL_DELAY_RST;
      func_lo_r       <= `DIFL_FUNC_LO_RST;
      func_hi_r       <= `DIFL_FUNC_HI_RST;
      pol_r           <= `DIFL_POL_RST;
      istat_r         <= {`DIFL_IRQ_W{1'b0}};
      imask_r         <= {`DIFL_IRQ_W{1'b0}};
      kreset_r        <= 1'b0;
      irq             <= 1'b0;
    end else begin
      kreset_r <= 1'b0;
      if (req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_mux;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_go) begin
        if (avs_address == `DIFL_OFS_CTRL) begin
          ctrl_r   <= avs_writedata[1:0];
          kreset_r <= avs_writedata[`DIFL_CTRL_KRESET];
        end else if (avs_address == `DIFL_OFS_DELAY) begin
          delay_r <= avs_writedata[15:0];
        end else if (avs_address == `DIFL_OFS_FUNC_LO) begin
          func_lo_r <= avs_writedata;
        end else if (avs_address == `DIFL_OFS_FUNC_HI) begin
          func_hi_r <= avs_writedata[23:0];
        end else if (avs_address == `DIFL_OFS_POL) begin
          pol_r <= avs_writedata[`DIFL_NTERM-1:0];
        end else if (avs_address == `DIFL_OFS_IRQ_MASK) begin
          imask_r <= avs_writedata[`DIFL_IRQ_W-1:0];
        end
      end
      // a new event in the clearing cycle survives the write of one
      if (wr_go && avs_address == `DIFL_OFS_IRQ_STAT) begin
        istat_r <= (istat_r & ~avs_writedata[`DIFL_IRQ_W-1:0]) | ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      // level interrupt, one cycle behind the status bits
      irq <= |(istat_r & imask_r);
    end
  end
endmodule
`default_nettype wire

//--- rtl/difl_regs.vh
// register map, field positions, reset values and timing counts
`ifndef DIFL_REGS_VH
`define DIFL_REGS_VH
`define DIFL_ADDR_W        6
`define DIFL_OFS_CTRL      6'h00
`define DIFL_OFS_DELAY     6'h04
`define DIFL_OFS_FUNC_LO   6'h08
`define DIFL_OFS_FUNC_HI   6'h0C
`define DIFL_OFS_POL       6'h10
`define DIFL_OFS_STATUS    6'h14
`define DIFL_OFS_IRQ_STAT  6'h18
`define DIFL_OFS_IRQ_MASK  6'h1C
`define DIFL_OFS_HIST      6'h20
`define DIFL_CTRL_GUARD    0
`define DIFL_CTRL_MODE     1
`define DIFL_CTRL_KRESET   2
`define DIFL_CTRL_RST      2'h0
`define DIFL_DELAY_RST     16'h0000
`define DIFL_POL_RST       7'h00
`define DIFL_FUNC_LO_RST   32'h0B08_0100
`define DIFL_FUNC_HI_RST   24'hFF_120C
`define DIFL_FN_FWD        8'h00
`define DIFL_FN_REV        8'h01
`define DIFL_FN_SET        8'h08
`define DIFL_FN_COAST      8'h0B
`define DIFL_FN_TRIP       8'h0C
`define DIFL_FN_RESET      8'h12
`define DIFL_ERR_NONE      8'h00
`define DIFL_ERR_EXT       8'h0C
`define DIFL_IRQ_TRIP      0
`define DIFL_IRQ_COAST     1
`define DIFL_IRQ_RESUME    2
`define DIFL_IRQ_SETCHG    3
`define DIFL_IRQ_W         4
`define DIFL_CLK_HZ        50000000
`define DIFL_TICK_MS       1
`define DIFL_TICK_CYC      ((`DIFL_CLK_HZ / 1000) * `DIFL_TICK_MS)
`define DIFL_DEB_NS        100
`define DIFL_DEB_CYC       ((`DIFL_DEB_NS * (`DIFL_CLK_HZ / 1000000) + 999) / 1000)
`define DIFL_NTERM         7
`endif

//--- rtl/difl_term.v
// one input terminal: debounce, polarity and function code match
`include "difl_regs.vh"
`default_nettype none
module difl_term (
  input  wire       mclk,
  input  wire       rst,
  input  wire       pin,
  input  wire       pol_low,
  input  wire [7:0] func,
  output reg  [5:0] hit
);
  localparam integer DEB_I = `DIFL_DEB_CYC;
  localparam [7:0]   DEB_N = DEB_I[7:0];
  reg [7:0] cnt_r;
  reg       lvl_r;
  wire      raw = pin ^ pol_low;

  // level only follows after DEB_N steady samples, so contact bounce is swallowed
  always @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 8'h00;
      lvl_r <= 1'b0;
      hit   <= 6'h00;
    end else begin
      if (raw == lvl_r) begin
        cnt_r <= 8'h00;
      end else if (cnt_r >= DEB_N - 8'h01) begin
        cnt_r <= 8'h00;
        lvl_r <= raw;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
      hit[0] <= lvl_r && (func == `DIFL_FN_FWD);
      hit[1] <= lvl_r && (func == `DIFL_FN_REV);
      hit[2] <= lvl_r && (func == `DIFL_FN_SET);
      hit[3] <= lvl_r && (func == `DIFL_FN_COAST);
      hit[4] <= lvl_r && (func == `DIFL_FN_TRIP);
      hit[5] <= lvl_r && (func == `DIFL_FN_RESET);
    end
  end
endmodule
`default_nettype wire

//--- tb/difl_core_monitor.sv
// checker on the drive input function logic ports
`include "difl_regs.vh"
`default_nettype none
module difl_core_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [6:0]  term_pin,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        drive_on,
  input wire logic        drive_reverse,
  input wire logic        motor_set2,
  input wire logic        alarm,
  input wire logic [7:0]  err_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] pol_r;
  logic [4:0] quiet_r;
  wire  [6:0] act = term_pin ^ pol_r;
  // polarity shadowed from the bus so pins compare as active levels
  always @(posedge mclk) begin
    if (rst)
      pol_r <= 7'h00;
    else if (avs_write && !avs_waitrequest && avs_address == `DIFL_OFS_POL)
      pol_r <= avs_writedata[6:0];
    if (rst || act[5] || avs_write)
      quiet_r <= 5'h00;
    else if (quiet_r != 5'h1F)
      quiet_r <= quiet_r + 5'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_coast_held;
    act[3] [*8] ##1 act[3] [*4];
  endsequence
  sequence s_both_held;
    (&act[1:0]) [*8] ##1 (&act[1:0]) [*4];
  endsequence
  sequence s_trip_rise;
    !act[4] ##1 act[4] [*8];
  endsequence
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_taken: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_set_hold: assert property (drive_on ##1 drive_on |-> $stable(motor_set2))
    else $error("set changed while running");
  a_dir_hold: assert property (drive_on ##1 drive_on |-> $stable(drive_reverse))
    else $error("direction changed while running");
  a_coast_off: assert property (s_coast_held |-> !drive_on)
    else $error("driving during coast");
  a_both_stop: assert property (s_both_held |-> !drive_on)
    else $error("driving with both directions");
  a_trip_latch: assert property (s_trip_rise |-> ##[0:3] alarm)
    else $error("trip not latched");
  a_trip_coast: assert property (alarm |-> !drive_on)
    else $error("driving while tripped");
  a_err_match: assert property (err_code == (alarm ? `DIFL_ERR_EXT : `DIFL_ERR_NONE))
    else $error("error code wrong");
  a_alarm_sticky: assert property (alarm && quiet_r > 5'h0C |=> alarm)
    else $error("trip left without reset");
endmodule
bind difl_core difl_core_monitor mon (.mclk(mclk), .rst(rst), .term_pin(term_pin),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .drive_on(drive_on),
  .drive_reverse(drive_reverse), .motor_set2(motor_set2), .alarm(alarm), .err_code(err_code));
`default_nettype wire

//--- tb/difl_ctl_model.sv
// contacts and controller driving the input terminals
`default_nettype none
module difl_ctl_model (
  input  wire logic       mclk,
  input  wire logic [6:0] want,
  input  wire logic       slow,
  output logic      [6:0] term_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] d1_r;
  logic [6:0] d2_r;
  // slow relays settle two cycles late
  always @(posedge mclk) begin
    d1_r <= want;
    d2_r <= d1_r;
    term_pin <= slow ? d2_r : want;
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the drive input function logic
`include "difl_regs.vh"
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  want = 7'h00;
  logic        slow = 1'b0;
  logic [6:0]  term_pin;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdata;
  logic        avs_waitrequest, drive_on, drive_reverse, motor_set2, start_from_speed;
  logic        alarm, irq;
  logic [7:0]  err_code;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [37:0] rows [11] = '{{`DIFL_OFS_CTRL, 32'h0}, {`DIFL_OFS_DELAY, 32'h0},
    {`DIFL_OFS_FUNC_LO, `DIFL_FUNC_LO_RST}, {`DIFL_OFS_FUNC_HI, 8'h00, `DIFL_FUNC_HI_RST},
    {`DIFL_OFS_POL, 32'h0}, {`DIFL_OFS_STATUS, 32'h0}, {`DIFL_OFS_IRQ_STAT, 32'h0},
    {`DIFL_OFS_IRQ_MASK, 32'h0}, {`DIFL_OFS_HIST, 32'h0}, {6'h24, 32'h0}, {6'h3C, 32'h0}};
  always #10 mclk = ~mclk;
  difl_core #(.TICK_CYC(10)) uut (.mclk(mclk), .rst(rst), .term_pin(term_pin),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drive_on(drive_on), .drive_reverse(drive_reverse),
    .motor_set2(motor_set2), .start_from_speed(start_from_speed), .alarm(alarm),
    .err_code(err_code), .irq(irq));
  difl_ctl_model ctl (.mclk(mclk), .want(want), .slow(slow), .term_pin(term_pin));
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask
  // bounded wait for the motor output to reach a level
  task drv(input logic v);
    int n;
    n = 0;
    while (drive_on !== v && n < 200) begin
      @(posedge mclk);
      n++;
    end
    `CHK(drive_on, v)
  endtask
  task done(input string s);
    $display("end of test %s", s);
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc(20000);
    err_total++;
    results();
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) rd(rows[i][37:32], rows[i][31:0]);
    xfer(1'b1, 6'h24, 32'hFFFF_FFFF);
    rd(6'h24, 32'h0);
    done("registers");
    want <= 7'h01;
    drv(1'b1);
    `CHK(drive_reverse, 1'b0)
    want <= 7'h05;
    cyc(20);
    `CHK(motor_set2, 1'b0)
    want <= 7'h04;
    drv(1'b0);
    cyc(12);
    `CHK(motor_set2, 1'b1)
    want <= 7'h05;
    drv(1'b1);
    want <= 7'h07;
    drv(1'b0);
    want <= 7'h02;
    drv(1'b1);
    `CHK(drive_reverse, 1'b1)
    want <= 7'h00;
    drv(1'b0);
    cyc(12);
    `CHK(motor_set2, 1'b0)
    done("run and set");
    xfer(1'b1, `DIFL_OFS_CTRL, 32'h2);
    xfer(1'b1, `DIFL_OFS_DELAY, 32'h2);
    want <= 7'h01;
    drv(1'b1);
    want <= 7'h09;
    drv(1'b0);
    want <= 7'h01;
    cyc(12);
    `CHK(drive_on, 1'b0)
    drv(1'b1);
    `CHK(start_from_speed, 1'b1)
    xfer(1'b1, `DIFL_OFS_CTRL, 32'h0);
    xfer(1'b1, `DIFL_OFS_DELAY, 32'h0);
    want <= 7'h09;
    drv(1'b0);
    want <= 7'h01;
    cyc(12);
    `CHK(drive_on, 1'b1)
    `CHK(start_from_speed, 1'b0)
    want <= 7'h09;
    drv(1'b0);
    want <= 7'h08;
    cyc(12);
    want <= 7'h00;
    cyc(12);
    `CHK(drive_on, 1'b0)
    xfer(1'b1, `DIFL_OFS_POL, 32'h8);
    want <= 7'h09;
    drv(1'b1);
    want <= 7'h01;
    drv(1'b0);
    xfer(1'b1, `DIFL_OFS_POL, 32'h0);
    xfer(1'b1, `DIFL_OFS_FUNC_HI, 32'h000B_120C);
    drv(1'b1);
    want <= 7'h41;
    drv(1'b0);
    xfer(1'b1, `DIFL_OFS_FUNC_HI, {8'h00, `DIFL_FUNC_HI_RST});
    done("coast");
    xfer(1'b1, `DIFL_OFS_IRQ_MASK, 32'h1);
    want <= 7'h01;
    drv(1'b1);
    slow <= 1'b1;
    want <= 7'h11;
    drv(1'b0);
    `CHK(alarm, 1'b1)
    `CHK(err_code, `DIFL_ERR_EXT)
    cyc(2);
    `CHK(irq, 1'b1)
    want <= 7'h01;
    cyc(14);
    want <= 7'h11;
    cyc(14);
    `CHK(alarm, 1'b1)
    rd(`DIFL_OFS_HIST, 32'h1);
    xfer(1'b0, `DIFL_OFS_STATUS, 32'h0);
    `CHK({rdata[15:8], rdata[5], rdata[2:0]}, {`DIFL_ERR_EXT, 1'b1, 3'h4})
    want <= 7'h21;
    cyc(14);
    `CHK(alarm, 1'b1)
    want <= 7'h01;
    drv(1'b1);
    `CHK(err_code, `DIFL_ERR_NONE)
    rd(`DIFL_OFS_HIST, 32'h0);
    xfer(1'b1, `DIFL_OFS_IRQ_STAT, 32'h1);
    cyc(2);
    `CHK(irq, 1'b0)
    slow <= 1'b0;
    done("trip");
    xfer(1'b1, `DIFL_OFS_IRQ_MASK, 32'h0);
    xfer(1'b1, `DIFL_OFS_CTRL, 32'h1);
    want <= 7'h11;
    drv(1'b0);
    want <= 7'h01;
    cyc(14);
    `CHK(irq, 1'b0)
    xfer(1'b1, `DIFL_OFS_CTRL, 32'h5);
    cyc(14);
    `CHK(alarm, 1'b0)
    `CHK(drive_on, 1'b0)
    xfer(1'b0, `DIFL_OFS_IRQ_STAT, 32'h0);
    `CHK(rdata[0], 1'b1)
    want <= 7'h00;
    cyc(14);
    want <= 7'h01;
    drv(1'b1);
    done("guard");
    results();
  end
endmodule
`default_nettype wire
